// *** frs_sequencer.v ***
// frs_sequencer.v: firing run scoring sequencer top
// assumes the trigger and fire pins are asynchronous and get two-flop synchronisers
`timescale 1ns/1ps
`include "frs_consts.vh"
module frs_sequencer #(
    parameter NUM_RANGES = `FRS_NUM_RANGES,
    parameter RANGE_W = `FRS_RANGE_W,
    parameter ACQ_W = 8,
    parameter DEV_W = 8,
    parameter WINDOW_CYC = `FRS_WINDOW_CYC,
    parameter TRIG_LAMP_CYC = `FRS_TRIG_LAMP_CYC
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    // launch simulator pins
    input wire trigger_pull,
    input wire fire_command,
    // instructor controls
    input wire [RANGE_W-1:0] range_select,
    input wire tracker_power_switch,
    input wire boresight_mode,
    // tracker inputs
    input wire [ACQ_W-1:0] acq_sum,
    input wire [ACQ_W-1:0] acq_threshold,
    input wire [DEV_W-1:0] los_deviation,
    input wire [DEV_W-1:0] deviation_allowance,
    // control outputs
    output reg scoring_enable,
    output reg tracker_power,
    output reg tracker_first_motion,
    output reg function_first_motion,
    output reg memory_reset,
    output reg run_latch_relay,
    output reg cam_inhibit,
    output reg meter_source_score,
    // lamps
    output reg trigger_lamp,
    output reg [NUM_RANGES-1:0] range_lamp,
    output reg hit_lamp,
    output reg miss_lamp,
    output reg [NUM_RANGES-1:0] error_lamp,
    output reg transmitter_acquired_lamp,
    // status
    output reg error_flag,
    output reg run_stop,
    output reg [RANGE_W:0] grade
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    reg trig_s1, trig_s2, trig_s3, fire_s1, fire_s2, fire_s3;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
            fire_s1 <= 1'b0;
            fire_s2 <= 1'b0;
            fire_s3 <= 1'b0;
        end else if (clk_en) begin
            trig_s1 <= trigger_pull;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            fire_s1 <= fire_command;
            fire_s2 <= fire_s1;
            fire_s3 <= fire_s2;
        end
    end
    wire trig_rise = trig_s2 & ~trig_s3;
    wire fire_rise = fire_s2 & ~fire_s3;

    // ----------------------------------------
    // state and counters
    // ----------------------------------------
    reg [1:0] state;
    reg [1:0] next_state;
    reg [31:0] win_cnt;
    reg [31:0] lamp_cnt;
    reg [RANGE_W-1:0] win_idx;
    reg win_valid;
    wire win_end = (win_cnt == WINDOW_CYC - 1);
    wire last_win = (win_idx == range_select);
    wire stop_now = (state == `FRS_ST_RUN) && win_end && last_win;

    always @* begin
        next_state = state;
        case (state)
            `FRS_ST_IDLE: begin
                if (trig_rise) begin
                    next_state = `FRS_ST_ARMED;
                end
            end
            `FRS_ST_ARMED: begin
                if (fire_rise) begin
                    next_state = `FRS_ST_RUN;
                end
            end
            `FRS_ST_RUN: begin
                if (stop_now) begin
                    next_state = `FRS_ST_DONE;
                end
            end
            `FRS_ST_DONE: begin
                if (trig_rise) begin
                    next_state = `FRS_ST_ARMED;
                end
            end
            default: begin
                next_state = `FRS_ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // memories
    // ----------------------------------------
    wire [NUM_RANGES-1:0] seg_error;
    wire any_error;
    wire [RANGE_W:0] mem_grade;
    frs_range_memory #(
        .NUM_RANGES(NUM_RANGES),
        .RANGE_W(RANGE_W)
    ) u_mem (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .clear(memory_reset),
        .window_valid(win_valid),
        .window_index(win_idx),
        .error_flag(error_flag),
        .seg_error(seg_error),
        .any_error(any_error),
        .grade(mem_grade)
    );

    localparam [RANGE_W+7:0] STEP_M = `FRS_RANGE_STEP_M;
    localparam [RANGE_W+7:0] CAM_LIMIT_M = `FRS_CAM_LIMIT_M;
    wire [RANGE_W+7:0] sel_meters = range_select * STEP_M;

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= `FRS_ST_IDLE;
            win_cnt <= 32'h0;
            lamp_cnt <= 32'h0;
            win_idx <= {RANGE_W{1'b0}};
            win_valid <= 1'b0;
            scoring_enable <= 1'b0;
            tracker_first_motion <= 1'b0;
            function_first_motion <= 1'b0;
            memory_reset <= 1'b0;
            run_latch_relay <= 1'b0;
            meter_source_score <= 1'b0;
            trigger_lamp <= 1'b0;
            range_lamp <= {NUM_RANGES{1'b0}};
            hit_lamp <= 1'b0;
            miss_lamp <= 1'b0;
            error_lamp <= {NUM_RANGES{1'b0}};
            run_stop <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            memory_reset <= 1'b0;
            run_stop <= stop_now;
            if (lamp_cnt != 32'h0) begin
                lamp_cnt <= lamp_cnt - 32'h1;
            end else begin
                trigger_lamp <= 1'b0;
            end
            if (trig_rise && state != `FRS_ST_RUN) begin
                scoring_enable <= 1'b1;
                tracker_first_motion <= 1'b1;
                memory_reset <= 1'b1;
                run_latch_relay <= 1'b1;
                trigger_lamp <= 1'b1;
                lamp_cnt <= TRIG_LAMP_CYC;
                meter_source_score <= 1'b0;
                hit_lamp <= 1'b0;
                miss_lamp <= 1'b0;
                error_lamp <= {NUM_RANGES{1'b0}};
            end
            if (state == `FRS_ST_ARMED && fire_rise) begin
                function_first_motion <= 1'b1;
                win_idx <= {RANGE_W{1'b0}};
                win_cnt <= 32'h0;
                win_valid <= 1'b1;
            end
            if (state == `FRS_ST_RUN) begin
                range_lamp <= {NUM_RANGES{1'b0}};
                range_lamp[win_idx] <= 1'b1;
                if (win_end) begin
                    win_cnt <= 32'h0;
                    if (!last_win) begin
                        win_idx <= win_idx + {{(RANGE_W-1){1'b0}}, 1'b1};
                    end
                end else begin
                    win_cnt <= win_cnt + 32'h1;
                end
            end
            if (run_stop) begin
                win_valid <= 1'b0;
                win_idx <= {RANGE_W{1'b0}};
                run_latch_relay <= 1'b0;
                scoring_enable <= 1'b0;
                tracker_first_motion <= 1'b0;
                function_first_motion <= 1'b0;
                range_lamp <= {NUM_RANGES{1'b0}};
                meter_source_score <= 1'b1;
                hit_lamp <= ~any_error;
                miss_lamp <= any_error;
            end
            // a new trigger must win over recall, or a stale error lamp survives into the run
            if (miss_lamp && state == `FRS_ST_DONE && !trig_rise) begin
                error_lamp <= {NUM_RANGES{1'b0}};
                error_lamp[range_select] <= seg_error[range_select];
            end
        end
    end

    // ----------------------------------------
    // tracker side outputs
    // ----------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tracker_power <= 1'b0;
            cam_inhibit <= 1'b0;
            transmitter_acquired_lamp <= 1'b0;
            error_flag <= 1'b0;
            grade <= {(RANGE_W+1){1'b0}};
        end else if (clk_en) begin
            tracker_power <= tracker_power_switch && (run_latch_relay || boresight_mode);
            cam_inhibit <= boresight_mode && (sel_meters < CAM_LIMIT_M);
            transmitter_acquired_lamp <= (acq_sum > acq_threshold);
            error_flag <= scoring_enable && (los_deviation > deviation_allowance);
            grade <= mem_grade;
        end
    end
endmodule // frs_sequencer

// *** frs_consts.vh ***
// frs_consts.vh: constants for the firing run scoring sequencer
// assumes a 200 MHz clock; included by bare name
`ifndef FRS_CONSTS_VH
`define FRS_CONSTS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define FRS_CLK_MHZ 200
`define FRS_FIRE_DELAY_MS 700
`define FRS_TRIG_LAMP_US 100
`define FRS_TRIG_LAMP_CYC (`FRS_TRIG_LAMP_US * `FRS_CLK_MHZ)
`define FRS_WINDOW_US 1000
`define FRS_WINDOW_CYC (`FRS_WINDOW_US * `FRS_CLK_MHZ)

// ----------------------------------------
// ranges
// ----------------------------------------
`define FRS_NUM_RANGES 8
`define FRS_RANGE_W 3
`define FRS_RANGE_STEP_M 100
`define FRS_CAM_LIMIT_M 300

// ----------------------------------------
// states
// ----------------------------------------
`define FRS_ST_IDLE 2'h0
`define FRS_ST_ARMED 2'h1
`define FRS_ST_RUN 2'h2
`define FRS_ST_DONE 2'h3

`endif

// *** frs_range_memory.v ***
// frs_range_memory.v: per-range error memory with decode and grade sum
// assumes inputs are synchronous to clk
`timescale 1ns/1ps
`include "frs_consts.vh"
module frs_range_memory #(
    parameter NUM_RANGES = `FRS_NUM_RANGES,
    parameter RANGE_W = `FRS_RANGE_W
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    // control
    input wire clear,
    input wire window_valid,
    input wire [RANGE_W-1:0] window_index,
    input wire error_flag,
    // results
    output wire [NUM_RANGES-1:0] seg_error,
    output wire any_error,
    output wire [RANGE_W:0] grade
);
    // ----------------------------------------
    // segment storage
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_RANGES; g = g + 1) begin : seg
            reg mem;
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    mem <= 1'b0;
                end else if (clk_en) begin
                    if (clear) begin
                        mem <= 1'b0;
                    end else if (window_valid && window_index == g && error_flag) begin
                        mem <= 1'b1;
                    end
                end
            end
            assign seg_error[g] = mem;
        end
    endgenerate

    // ----------------------------------------
    // summary
    // ----------------------------------------
    assign any_error = |seg_error;
    reg [RANGE_W:0] sum;
    integer i;
    always @* begin
        sum = {(RANGE_W+1){1'b0}};
        for (i = 0; i < NUM_RANGES; i = i + 1) begin
            sum = sum + {{RANGE_W{1'b0}}, seg_error[i]};
        end
    end
    assign grade = sum;
endmodule // frs_range_memory

// *** frs_sequencer_assertions.sv ***
// frs_sequencer_assertions.sv: checks on the sequencer ports
// assumes a bind into frs_sequencer and one clock domain
`timescale 1ns/1ps
module frs_sequencer_assertions #(
    parameter TRIG_LAMP_CYC = 4
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    // inputs
    input wire [2:0] range_select,
    input wire tracker_power_switch,
    input wire boresight_mode,
    input wire [7:0] acq_sum,
    input wire [7:0] acq_threshold,
    input wire [7:0] los_deviation,
    input wire [7:0] deviation_allowance,
    // outputs
    input wire scoring_enable,
    input wire tracker_power,
    input wire function_first_motion,
    input wire memory_reset,
    input wire run_latch_relay,
    input wire cam_inhibit,
    input wire meter_source_score,
    input wire trigger_lamp,
    input wire [7:0] range_lamp,
    input wire hit_lamp,
    input wire miss_lamp,
    input wire [7:0] error_lamp,
    input wire transmitter_acquired_lamp,
    input wire error_flag,
    input wire run_stop,
    input wire [3:0] grade
);
// ----------------------------------------
// helpers
// ----------------------------------------
reg [31:0] lamp_len;
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        lamp_len <= 32'h0;
    end else if (clk_en) begin
        lamp_len <= trigger_lamp ? lamp_len + 32'h1 : 32'h0;
    end
end
default clocking cb @(posedge clk); endclocking
default disable iff (!reset_n || !clk_en);
// ----------------------------------------
// checks
// ----------------------------------------
a_trigger_outputs: assert property ($rose(run_latch_relay) |->
    memory_reset && scoring_enable && trigger_lamp ##1 !memory_reset) else $error("trigger outputs");
a_lamp_length: assert property ($fell(trigger_lamp) |-> lamp_len == TRIG_LAMP_CYC + 1)
    else $error("trigger lamp length");
a_fire_start: assert property ($rose(function_first_motion) |-> run_latch_relay ##1 range_lamp == 8'h01)
    else $error("fire start");
a_window_step: assert property (range_lamp != 8'h00 && $past(range_lamp) != 8'h00 && $changed(range_lamp)
    |-> range_lamp == $past(range_lamp) << 1) else $error("window step");
a_one_window: assert property ($onehot0(range_lamp)) else $error("two windows");
a_stop_effects: assert property (run_stop |=> !run_stop && (hit_lamp ^ miss_lamp) &&
    miss_lamp == (grade != 4'h0) && meter_source_score && !run_latch_relay) else $error("stop effects");
a_recall_lamp: assert property (error_lamp != 8'h00 && $past(clk_en) |->
    miss_lamp && error_lamp == 8'h01 << $past(range_select)) else $error("recall lamp");
a_cam_inhibit: assert property ($past(reset_n) && $past(clk_en) |->
    cam_inhibit == $past(boresight_mode && range_select < 3'h3)) else $error("cam inhibit");
a_tracker_power: assert property ($past(reset_n) && $past(clk_en) |->
    tracker_power == $past(tracker_power_switch && (run_latch_relay || boresight_mode))) else $error("power");
a_acq_lamp: assert property ($past(reset_n) && $past(clk_en) |->
    transmitter_acquired_lamp == $past(acq_sum > acq_threshold)) else $error("acquired lamp");
a_error_flag: assert property (scoring_enable && $past(scoring_enable) && $past(clk_en) |->
    error_flag == $past(los_deviation > deviation_allowance)) else $error("error flag");
endmodule // frs_sequencer_assertions
bind frs_sequencer frs_sequencer_assertions #(.TRIG_LAMP_CYC(TRIG_LAMP_CYC)) i_chk (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .range_select(range_select),
    .tracker_power_switch(tracker_power_switch),
    .boresight_mode(boresight_mode),
    .acq_sum(acq_sum),
    .acq_threshold(acq_threshold),
    .los_deviation(los_deviation),
    .deviation_allowance(deviation_allowance),
    .scoring_enable(scoring_enable),
    .tracker_power(tracker_power),
    .function_first_motion(function_first_motion),
    .memory_reset(memory_reset),
    .run_latch_relay(run_latch_relay),
    .cam_inhibit(cam_inhibit),
    .meter_source_score(meter_source_score),
    .trigger_lamp(trigger_lamp),
    .range_lamp(range_lamp),
    .hit_lamp(hit_lamp),
    .miss_lamp(miss_lamp),
    .error_lamp(error_lamp),
    .transmitter_acquired_lamp(transmitter_acquired_lamp),
    .error_flag(error_flag),
    .run_stop(run_stop),
    .grade(grade)
);

// *** frs_launch_model.sv ***
// frs_launch_model.sv: launch simulator and tracker stand-in
// assumes go pulses from the bench; windows are read off range_lamp
`timescale 1ns/1ps
module frs_launch_model #(
    parameter FIRE_DLY = 20
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // bench control
    input wire go,
    input wire [7:0] err_mask,
    input wire [7:0] range_lamp,
    // pins toward the sequencer
    output reg trigger_pull,
    output reg fire_command,
    output wire [7:0] los_deviation,
    output reg [7:0] acq_sum
);
reg [7:0] last_lamp;
reg [3:0] age;
initial begin
    trigger_pull = 1'b0;
    fire_command = 1'b0;
end
// fire command follows trigger after a scaled delay
always @(posedge go) begin
    trigger_pull <= 1'b1;
    repeat (FIRE_DLY) @(posedge clk);
    fire_command <= 1'b1;
    repeat (6) @(posedge clk);
    trigger_pull <= 1'b0;
    fire_command <= 1'b0;
end
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        last_lamp <= 8'h00;
        age <= 4'h0;
        acq_sum <= 8'h00;
    end else begin
        last_lamp <= range_lamp;
        age <= (range_lamp != last_lamp) ? 4'h0 : age + 4'h1;
        acq_sum <= acq_sum + 8'h1D;
    end
end
// deviation only mid-window, so it never spills into a neighbour
assign los_deviation = (|(range_lamp & err_mask) && age >= 4'h1 && age <= 4'h3) ? 8'hFF : 8'h00;
endmodule // frs_launch_model

// *** frs_sequencer_tb.sv ***
// frs_sequencer_tb.sv: self-checking bench for the sequencer
// assumes short window and lamp counts set at the instance
`timescale 1ns/1ps
module frs_sequencer_tb;
reg clk = 1'b0;
reg reset_n = 1'b0;
reg go = 1'b0;
reg clk_en = 1'b1;
reg [2:0] range_select = 3'h0;
reg tracker_power_switch = 1'b0;
reg boresight_mode = 1'b0;
reg [7:0] acq_threshold = 8'h00;
reg [7:0] deviation_allowance = 8'h00;
reg [7:0] err_mask = 8'h00;
wire trigger_pull, fire_command, scoring_enable, tracker_power, tracker_first_motion, function_first_motion;
wire memory_reset, run_latch_relay, cam_inhibit, meter_source_score, trigger_lamp, hit_lamp, miss_lamp;
wire transmitter_acquired_lamp, error_flag, run_stop;
wire [7:0] acq_sum, los_deviation, range_lamp, error_lamp;
wire [3:0] grade;
integer num_errors = 0;
integer samples_checked = 0;
integer s, r, n;
reg [31:0] seed = 32'hA0F0;
reg [7:0] m;
always #2.5 clk = ~clk;
frs_sequencer #(.WINDOW_CYC(8), .TRIG_LAMP_CYC(4)) i_dut (.*);
frs_launch_model #(.FIRE_DLY(20)) i_far (.*);
// ----------------------------------------
// helpers
// ----------------------------------------
function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
endfunction
function automatic logic [3:0] pop(input logic [7:0] v);
    pop = 4'h0;
    for (int i = 0; i < 8; i++) pop = pop + v[i];
endfunction
task wrap_up;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked = samples_checked + 1;
    if (e !== g) begin
        $display("wrong value %s expected %h seen %h", nm, e, g);
        num_errors = num_errors + 1;
    end
endtask
task wt(input integer k);
    n = 0;
    while (((k == 0) ? range_lamp[0] : run_stop) !== 1'b1 && n < 500) begin
        @(negedge clk);
        n = n + 1;
    end
    if (n == 500) begin
        chk("wait", 8'h01, 8'h00);
        wrap_up;
    end
endtask
// ----------------------------------------
// sequence
// ----------------------------------------
initial begin
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    for (s = 0; s < 6; s++) begin
        seed = xs(seed);
        range_select = (s == 1) ? 3'h0 : (s < 3) ? 3'h7 : seed[2:0];
        err_mask = (s == 0) ? 8'h00 : (s < 3) ? 8'hFF : seed[15:8];
        tracker_power_switch = seed[16];
        deviation_allowance = {1'b0, seed[23:17]};
        acq_threshold = seed[31:24];
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        wt(0);
        chk("meter", 8'h00, meter_source_score);
        chk("first_motion", 8'h01, function_first_motion);
        chk("tracker_motion", 8'h01, tracker_first_motion);
        wt(1);
        repeat (2) @(negedge clk);
        m = err_mask & ((9'h002 << range_select) - 9'h001);
        chk("miss", |m, miss_lamp);
        chk("hit", ~|m, hit_lamp);
        chk("grade", pop(m), grade);
        chk("latch", 8'h00, run_latch_relay);
        for (r = 7; r >= 0 && |m; r--) begin
            range_select = r[2:0];
            repeat (2) @(negedge clk);
            chk("error_lamp", m[r] ? 8'h01 << r : 8'h00, error_lamp);
        end
    end
    boresight_mode = 1'b1;
    for (r = 0; r < 8; r++) begin
        range_select = r[2:0];
        tracker_power_switch = r[0];
        repeat (2) @(negedge clk);
        chk("cam", r < 3, cam_inhibit);
        chk("power", r[0], tracker_power);
        m = acq_sum;
        @(negedge clk);
        chk("acquired", m > acq_threshold, transmitter_acquired_lamp);
    end
    // clock enable low must hold every output
    clk_en = 1'b0;
    range_select = 3'h0;
    repeat (2) @(negedge clk);
    chk("frozen_cam", 8'h00, cam_inhibit);
    clk_en = 1'b1;
    repeat (2) @(negedge clk);
    chk("cam", 8'h01, cam_inhibit);
    wrap_up;
end
endmodule // frs_sequencer_tb
